//--- usart_pkg.sv
// Shared constants, types and helpers of the serial clock and frame block.
`default_nettype none

package usart_pkg;

   // ******************************************************************
   // Widths and counts
   // ******************************************************************
   localparam int DIVISOR_W = 12;
   localparam int HIGH_BYTE_W = 4;
   localparam int CHAR_W = 9;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] LAST_PHASE_NORMAL = 4'hF;
   localparam logic [CNT_W-1:0] LAST_PHASE_DOUBLE = 4'h7;
   localparam logic [CNT_W-1:0] LAST_PHASE_SYNC = 4'h1;
   localparam logic [CNT_W-1:0] MID_PHASE_NORMAL = 4'h7;
   localparam logic [CNT_W-1:0] MID_PHASE_DOUBLE = 4'h3;
   localparam logic [CNT_W-1:0] MIN_DATA_BITS = 4'h5;
   localparam logic [CNT_W-1:0] NINE_DATA_BITS = 4'h9;

   // ******************************************************************
   // Field codes and reset values
   // ******************************************************************
   localparam logic [2:0] CHAR_SIZE_NINE = 3'h7;
   localparam int PARITY_ENABLE_POS = 1;
   localparam int PARITY_ODD_POS = 0;
   localparam logic [DIVISOR_W-1:0] DIVISOR_RESET = 12'h000;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic START_LEVEL = 1'b0;

   // ******************************************************************
   // Types
   // ******************************************************************
   typedef struct packed {
      logic sync_mode_select;
      logic clock_pin_direction;
      logic sync_clock_polarity;
      logic double_speed_select;
      logic [2:0] char_size_field;
      logic [1:0] parity_mode_field;
      logic stop_bits_select;
   } cfg_t;

   typedef struct packed {
      logic [CHAR_W-1:0] data;
      logic frame_error_flag;
      logic parity_error;
   } rx_word_t;

   typedef enum logic [4:0] {
      LINE_IDLE_ST = 5'h01,
      LINE_START_ST = 5'h02,
      LINE_DATA_ST = 5'h04,
      LINE_PARITY_ST = 5'h08,
      LINE_STOP_ST = 5'h10
   } line_state_t;

   // ******************************************************************
   // Helpers
   // ******************************************************************
   function automatic logic [CNT_W-1:0] data_bits(input logic [2:0] size);
      data_bits = (size == CHAR_SIZE_NINE) ? NINE_DATA_BITS :
         MIN_DATA_BITS + {2'h0, size[1:0]};
   endfunction

   function automatic logic parity_bit(input logic [CHAR_W-1:0] d,
         input logic [2:0] size, input logic odd);
      logic p;
      p = odd;
      for (int i = 0; i < CHAR_W; i++) begin
         if (CNT_W'(i) < data_bits(size)) begin
            p = p ^ d[i];
         end
      end
      parity_bit = p;
   endfunction

endpackage

`default_nettype wire

//--- baud_generator.sv
// Down-counting baud rate generator with reload on the low divisor write.
`default_nettype none

module baud_generator (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clock_en,
   // Divisor
   input wire logic [usart_pkg::DIVISOR_W-1:0] i_divisor,
   input wire logic i_reload,
   // Tick out
   output logic o_tick
);

   logic [usart_pkg::DIVISOR_W-1:0] count_q;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         count_q <= usart_pkg::DIVISOR_RESET;
      end else if (i_clock_en) begin
         if (i_reload || count_q == '0) begin
            count_q <= i_divisor;
         end else begin
            count_q <= count_q - 1'b1;
         end
      end
   end

   assign o_tick = i_clock_en && !i_reload && count_q == '0;

endmodule

`default_nettype wire

//--- clock_edge_sync.sv
// Synchroniser and edge detector for the external transfer clock.
`default_nettype none

module clock_edge_sync (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clock_en,
   // Pin and edges
   input wire logic i_pin,
   output logic o_rise,
   output logic o_fall
);

   logic meta_q;
   logic sync_q;
   logic last_q;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else if (i_clock_en) begin
         meta_q <= i_pin;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign o_rise = i_clock_en && sync_q && !last_q;
   assign o_fall = i_clock_en && !sync_q && last_q;

endmodule

`default_nettype wire

//--- usart_clock_and_frame_format.sv
// Clock generation, framing transmitter and receiver of the serial block.
`default_nettype none

// Notes on behaviour
// - Counter reloads at zero and low write
// - One tick per divisor plus one clocks
// - Transmit bit clock divides tick 16/8/2
// - Receiver recovery uses 2, 8, 16 phases
// - Divisor is twelve bits from two bytes
// - Double speed only matters when asynchronous
// - Double speed gives eight samples per bit
// - External clock synchronised then edge detected
// - Clock pin output as master, input slave
// - Sample on edge opposite to change
// - Polarity swaps change and sample edges
// - All thirty frame formats are supported
// - Start, data LSB first, parity, stops
// - Start low, stop high, idle high
// - Format change aborts both directions
// - Only first stop bit checked for error
// - Parity is data xor, inverted when odd
// - Size, parity, stop fields select format
// - Mode select and pin direction pick clocking
// - Size seven means nine bits, ninth separate
// - Parity inserted only when upper bit set
module usart_clock_and_frame_format (
   // Clock, reset and enable
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clock_en,
   // Configuration
   input wire usart_pkg::cfg_t i_cfg,
   input wire logic [usart_pkg::HIGH_BYTE_W-1:0] i_baud_divisor_high_byte,
   input wire logic [7:0] i_baud_divisor_low_byte,
   input wire logic i_low_byte_write,
   // Transmit side
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   input wire logic i_ninth_transmit_bit,
   output logic o_tx_ready,
   output logic o_transmit_complete_flag,
   input wire logic i_transmit_complete_clear,
   // Receive side
   output logic o_rx_valid,
   output var usart_pkg::rx_word_t o_rx_word,
   output logic o_receive_complete_flag,
   input wire logic i_receive_complete_clear,
   // Serial pins
   input wire logic i_serial_receive_pin,
   output logic o_serial_transmit_pin,
   input wire logic i_transfer_clock_pin,
   output logic o_transfer_clock_pin,
   output logic o_transfer_clock_oe
);

   // ******************************************************************
   // Declarations
   // ******************************************************************
   logic baud_tick;
   logic ext_rise;
   logic ext_fall;
   logic sync_master;
   logic sync_slave;
   logic clk_rise;
   logic clk_fall;
   logic change_edge;
   logic sample_edge;
   logic [usart_pkg::CNT_W-1:0] last_phase;
   logic [usart_pkg::CNT_W-1:0] mid_phase;
   logic [usart_pkg::CNT_W-1:0] nbits;
   logic parity_on;
   logic [5:0] fmt;
   logic [5:0] fmt_q;
   logic fmt_change;
   logic [usart_pkg::CNT_W-1:0] tx_phase_q;
   logic tx_bit_tick;
   logic [usart_pkg::CHAR_W-1:0] hold_q;
   logic hold_valid_q;
   logic tx_take;
   logic tx_done;
   usart_pkg::line_state_t tx_state_q;
   logic [usart_pkg::CHAR_W-1:0] tx_shift_q;
   logic [usart_pkg::CNT_W-1:0] tx_cnt_q;
   logic tx_par_q;
   logic tx_second_q;
   logic tx_line_q;
   logic tx_flag_q;
   usart_pkg::line_state_t rx_state_q;
   logic [usart_pkg::CNT_W-1:0] rx_phase_q;
   logic [usart_pkg::CNT_W-1:0] rx_cnt_q;
   logic [usart_pkg::CHAR_W-1:0] rx_shift_q;
   logic rx_par_q;
   logic rx_sample;
   logic rx_start;
   logic rx_valid_q;
   usart_pkg::rx_word_t rx_word_q;
   logic rx_flag_q;
   logic xck_out_q;
   logic xck_oe_q;

   // ******************************************************************
   // Baud generator and external clock
   // ******************************************************************
   // twelve bit divisor
   baud_generator u_baud (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_clock_en(i_clock_en),
      .i_divisor({i_baud_divisor_high_byte, i_baud_divisor_low_byte}),
      .i_reload(i_low_byte_write),
      .o_tick(baud_tick)
   );

   clock_edge_sync u_edge (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_clock_en(i_clock_en),
      .i_pin(i_transfer_clock_pin),
      .o_rise(ext_rise),
      .o_fall(ext_fall)
   );

   // ******************************************************************
   // Mode decode and transfer clock
   // ******************************************************************
   // mode and direction
   assign sync_master = i_cfg.sync_mode_select && i_cfg.clock_pin_direction;
   assign sync_slave = i_cfg.sync_mode_select && !i_cfg.clock_pin_direction;

   always_comb begin
      if (i_cfg.sync_mode_select) begin
         last_phase = usart_pkg::LAST_PHASE_SYNC;
      end else if (i_cfg.double_speed_select) begin
         last_phase = usart_pkg::LAST_PHASE_DOUBLE;
      end else begin
         last_phase = usart_pkg::LAST_PHASE_NORMAL;
      end
      mid_phase = i_cfg.double_speed_select ? usart_pkg::MID_PHASE_DOUBLE
         : usart_pkg::MID_PHASE_NORMAL;
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         xck_out_q <= 1'b0;
      end else if (i_clock_en) begin
         if (!sync_master) begin
            xck_out_q <= i_cfg.sync_clock_polarity;
         end else if (baud_tick) begin
            xck_out_q <= !xck_out_q;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         xck_oe_q <= 1'b0;
      end else if (i_clock_en) begin
         xck_oe_q <= sync_master;
      end
   end

   assign clk_rise = (sync_master && baud_tick && !xck_out_q) ||
      (sync_slave && ext_rise);
   assign clk_fall = (sync_master && baud_tick && xck_out_q) ||
      (sync_slave && ext_fall);

   assign change_edge = i_cfg.sync_clock_polarity ? clk_fall : clk_rise;
   assign sample_edge = i_cfg.sync_clock_polarity ? clk_rise : clk_fall;

   // ******************************************************************
   // Frame format
   // ******************************************************************
   // format fields
   assign nbits = usart_pkg::data_bits(i_cfg.char_size_field);
   assign parity_on = i_cfg.parity_mode_field[usart_pkg::PARITY_ENABLE_POS];
   assign fmt = {i_cfg.char_size_field, i_cfg.parity_mode_field,
      i_cfg.stop_bits_select};

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         fmt_q <= 6'h00;
      end else if (i_clock_en) begin
         fmt_q <= fmt;
      end
   end

   assign fmt_change = fmt != fmt_q;

   // ******************************************************************
   // Transmitter bit clock
   // ******************************************************************
   // divide by 16, 8, 2
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         tx_phase_q <= 4'h0;
      end else if (i_clock_en && baud_tick) begin
         if (tx_phase_q >= last_phase) begin
            tx_phase_q <= 4'h0;
         end else begin
            tx_phase_q <= tx_phase_q + 4'h1;
         end
      end
   end

   assign tx_bit_tick = i_cfg.sync_mode_select ? change_edge :
      (baud_tick && tx_phase_q >= last_phase);

   // ******************************************************************
   // Transmit holding register
   // ******************************************************************
   assign o_tx_ready = !hold_valid_q;
   assign tx_take = tx_bit_tick && hold_valid_q && !fmt_change &&
      (tx_state_q == usart_pkg::LINE_IDLE_ST ||
       (tx_state_q == usart_pkg::LINE_STOP_ST && !tx_second_q));
   assign tx_done = tx_bit_tick && !hold_valid_q && !fmt_change &&
      tx_state_q == usart_pkg::LINE_STOP_ST && !tx_second_q;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         hold_q <= 9'h000;
         hold_valid_q <= 1'b0;
      end else if (i_clock_en) begin
         if (i_tx_valid && !hold_valid_q) begin
            hold_q <= {i_ninth_transmit_bit, i_tx_data};
            hold_valid_q <= 1'b1;
         end else if (tx_take) begin
            hold_valid_q <= 1'b0;
         end
      end
   end

   // ******************************************************************
   // Transmit frame sequencer
   // ******************************************************************
   // frame order
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         tx_state_q <= usart_pkg::LINE_IDLE_ST;
         tx_shift_q <= 9'h000;
         tx_cnt_q <= 4'h0;
         tx_par_q <= 1'b0;
         tx_second_q <= 1'b0;
         tx_line_q <= usart_pkg::LINE_IDLE;
      end else if (i_clock_en) begin
         if (fmt_change) begin
            tx_state_q <= usart_pkg::LINE_IDLE_ST;
            tx_line_q <= usart_pkg::LINE_IDLE;
         end else if (tx_take) begin
            tx_state_q <= usart_pkg::LINE_START_ST;
            tx_shift_q <= hold_q;
            tx_par_q <= usart_pkg::parity_bit(hold_q,
               i_cfg.char_size_field,
               i_cfg.parity_mode_field[usart_pkg::PARITY_ODD_POS]);
            tx_cnt_q <= 4'h0;
            tx_line_q <= usart_pkg::START_LEVEL;
         end else if (tx_bit_tick) begin
            case (tx_state_q)
               usart_pkg::LINE_IDLE_ST: begin
                  tx_line_q <= usart_pkg::LINE_IDLE;
               end
               usart_pkg::LINE_START_ST, usart_pkg::LINE_DATA_ST: begin
                  if (tx_cnt_q < nbits) begin
                     tx_state_q <= usart_pkg::LINE_DATA_ST;
                     tx_line_q <= tx_shift_q[tx_cnt_q];
                     tx_cnt_q <= tx_cnt_q + 4'h1;
                  end else if (parity_on) begin
                     tx_state_q <= usart_pkg::LINE_PARITY_ST;
                     tx_line_q <= tx_par_q;
                  end else begin
                     tx_state_q <= usart_pkg::LINE_STOP_ST;
                     tx_second_q <= i_cfg.stop_bits_select;
                     tx_line_q <= usart_pkg::LINE_IDLE;
                  end
               end
               usart_pkg::LINE_PARITY_ST: begin
                  tx_state_q <= usart_pkg::LINE_STOP_ST;
                  tx_second_q <= i_cfg.stop_bits_select;
                  tx_line_q <= usart_pkg::LINE_IDLE;
               end
               usart_pkg::LINE_STOP_ST: begin
                  if (tx_second_q) begin
                     tx_second_q <= 1'b0;
                  end else begin
                     tx_state_q <= usart_pkg::LINE_IDLE_ST;
                  end
                  tx_line_q <= usart_pkg::LINE_IDLE;
               end
               default: begin
                  tx_state_q <= usart_pkg::LINE_IDLE_ST;
                  tx_line_q <= usart_pkg::LINE_IDLE;
               end
            endcase
         end
      end
   end

   assign o_serial_transmit_pin = tx_line_q;

   // The completion flag is set when a frame ends with nothing queued.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         tx_flag_q <= 1'b0;
      end else if (i_clock_en) begin
         if (tx_done) begin
            tx_flag_q <= 1'b1;
         end else if (i_transmit_complete_clear) begin
            tx_flag_q <= 1'b0;
         end
      end
   end

   assign o_transmit_complete_flag = tx_flag_q;

   // ******************************************************************
   // Receiver clock recovery
   // ******************************************************************
   // phase counter on tick
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         rx_phase_q <= 4'h0;
      end else if (i_clock_en) begin
         if (rx_state_q == usart_pkg::LINE_IDLE_ST) begin
            rx_phase_q <= 4'h0;
         end else if (baud_tick) begin
            if (rx_phase_q >= last_phase) begin
               rx_phase_q <= 4'h0;
            end else begin
               rx_phase_q <= rx_phase_q + 4'h1;
            end
         end
      end
   end

   // A low line at an idle tick or sample edge opens a frame.
   assign rx_start = i_cfg.sync_mode_select ?
      (sample_edge && !i_serial_receive_pin) :
      (baud_tick && !i_serial_receive_pin);
   assign rx_sample = i_cfg.sync_mode_select ? sample_edge :
      (baud_tick && rx_phase_q == mid_phase);

   // ******************************************************************
   // Receive frame sequencer
   // ******************************************************************
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         rx_state_q <= usart_pkg::LINE_IDLE_ST;
         rx_cnt_q <= 4'h0;
         rx_shift_q <= 9'h000;
         rx_par_q <= 1'b0;
         rx_valid_q <= 1'b0;
         rx_word_q <= '0;
      end else if (i_clock_en) begin
         rx_valid_q <= 1'b0;
         if (fmt_change) begin
            rx_state_q <= usart_pkg::LINE_IDLE_ST;
         end else begin
            case (rx_state_q)
               usart_pkg::LINE_IDLE_ST: begin
                  if (rx_start) begin
                     rx_state_q <= i_cfg.sync_mode_select ?
                        usart_pkg::LINE_DATA_ST : usart_pkg::LINE_START_ST;
                     rx_cnt_q <= 4'h0;
                     rx_shift_q <= 9'h000;
                  end
               end
               usart_pkg::LINE_START_ST: begin
                  if (rx_sample) begin
                     rx_state_q <= i_serial_receive_pin ?
                        usart_pkg::LINE_IDLE_ST : usart_pkg::LINE_DATA_ST;
                  end
               end
               usart_pkg::LINE_DATA_ST: begin
                  if (rx_sample) begin
                     rx_shift_q[rx_cnt_q] <= i_serial_receive_pin;
                     rx_cnt_q <= rx_cnt_q + 4'h1;
                     if (rx_cnt_q + 4'h1 >= nbits) begin
                        rx_state_q <= parity_on ?
                           usart_pkg::LINE_PARITY_ST :
                           usart_pkg::LINE_STOP_ST;
                     end
                  end
               end
               usart_pkg::LINE_PARITY_ST: begin
                  if (rx_sample) begin
                     rx_par_q <= i_serial_receive_pin;
                     rx_state_q <= usart_pkg::LINE_STOP_ST;
                  end
               end
               usart_pkg::LINE_STOP_ST: begin
                  if (rx_sample) begin
                     rx_state_q <= usart_pkg::LINE_IDLE_ST;
                     rx_valid_q <= 1'b1;
                     rx_word_q.data <= rx_shift_q;
                     rx_word_q.frame_error_flag <= !i_serial_receive_pin;
                     rx_word_q.parity_error <= parity_on &&
                        (rx_par_q != usart_pkg::parity_bit(rx_shift_q,
                        i_cfg.char_size_field,
                        i_cfg.parity_mode_field[usart_pkg::PARITY_ODD_POS]));
                  end
               end
               default: begin
                  rx_state_q <= usart_pkg::LINE_IDLE_ST;
               end
            endcase
         end
      end
   end

   // A new character wins over a clear in the same cycle.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         rx_flag_q <= 1'b0;
      end else if (i_clock_en) begin
         if (rx_valid_q) begin
            rx_flag_q <= 1'b1;
         end else if (i_receive_complete_clear) begin
            rx_flag_q <= 1'b0;
         end
      end
   end

   // ******************************************************************
   // Outputs
   // ******************************************************************
   assign o_rx_valid = rx_valid_q;
   assign o_rx_word = rx_word_q;
   assign o_receive_complete_flag = rx_flag_q;
   assign o_transfer_clock_pin = xck_out_q;
   assign o_transfer_clock_oe = xck_oe_q;

endmodule

`default_nettype wire

//--- usart_monitor.sv
// Concurrent checks on the ports of the serial clock and frame block.
`default_nettype none
module usart_monitor (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clock_en,
   input wire usart_pkg::cfg_t i_cfg,
   input wire logic i_tx_valid,
   input wire logic o_tx_ready,
   input wire logic o_rx_valid,
   input wire usart_pkg::rx_word_t o_rx_word,
   input wire logic o_receive_complete_flag,
   input wire logic o_serial_transmit_pin,
   input wire logic o_transfer_clock_pin,
   input wire logic o_transfer_clock_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   reset_state_a: assert property (disable iff (1'b0) i_rst |=>
      o_serial_transmit_pin && !o_transfer_clock_oe && !o_rx_valid && o_tx_ready)
      else $error("outputs not at rest after reset");
   clock_oe_a: assert property (i_clock_en |=> o_transfer_clock_oe ==
      $past(i_cfg.sync_mode_select && i_cfg.clock_pin_direction))
      else $error("clock pin enable wrong for mode");
   clock_idle_a: assert property (i_clock_en &&
      !(i_cfg.sync_mode_select && i_cfg.clock_pin_direction) |=>
      o_transfer_clock_pin == $past(i_cfg.sync_clock_polarity))
      else $error("clock pin not at polarity level");
   ready_drop_a: assert property (i_tx_valid && o_tx_ready && i_clock_en
      |=> !o_tx_ready) else $error("ready stayed high after load");
   rx_pulse_a: assert property (o_rx_valid && i_clock_en |=> !o_rx_valid)
      else $error("receive valid longer than one cycle");
   rx_flag_a: assert property (o_rx_valid && i_clock_en |=>
      o_receive_complete_flag) else $error("receive flag not set");
   parity_off_a: assert property (o_rx_valid &&
      !i_cfg.parity_mode_field[1] |-> !o_rx_word.parity_error)
      else $error("parity error with parity off");
   format_abort_a: assert property (i_clock_en && $changed(i_cfg[5:0])
      |-> ##[1:2] o_serial_transmit_pin) else $error("line not idle on change");
endmodule
bind usart_clock_and_frame_format usart_monitor mon (.i_clock(i_clock),
   .i_rst(i_rst), .i_clock_en(i_clock_en), .i_cfg(i_cfg),
   .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid),
   .o_rx_word(o_rx_word), .o_receive_complete_flag(o_receive_complete_flag),
   .o_serial_transmit_pin(o_serial_transmit_pin),
   .o_transfer_clock_pin(o_transfer_clock_pin),
   .o_transfer_clock_oe(o_transfer_clock_oe));
`default_nettype wire

//--- serial_peer.sv
// Remote serial peer that echoes the line and makes a slave clock.
`default_nettype none
module serial_peer (
   input wire logic i_clock,
   input wire logic i_line_in,
   input wire logic i_hold_low,
   input wire logic i_clk_run,
   input wire logic i_idle_level,
   output logic o_line_out,
   output logic o_ext_clock
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] div_q = 2'h0;
   initial o_line_out = 1'b1;
   initial o_ext_clock = 1'b0;
   // frames echoed, stop broken on command.
   always @(posedge i_clock) begin
      o_line_out <= i_line_in & ~i_hold_low;
   end
   // clock at an eighth of system rate, still outside slave mode.
   always @(posedge i_clock) begin
      div_q <= div_q + 2'h1;
      if (!i_clk_run) o_ext_clock <= i_idle_level;
      else if (div_q == 2'h3) o_ext_clock <= ~o_ext_clock;
   end
endmodule
`default_nettype wire

//--- usart_clock_and_frame_format_tb_top.sv
// Self-checking bench of the serial clock and frame block.
`default_nettype none
module usart_clock_and_frame_format_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic low_wr = 1'b0, tx_valid = 1'b0, ninth = 1'b0, hold = 1'b0;
   logic tc_clr = 1'b0, rc_clr = 1'b0, xck_oe;
   logic [7:0] div_lo = 8'h01, tx_data = 8'h00;
   usart_pkg::cfg_t cfg = '0;
   usart_pkg::rx_word_t rx_word;
   logic tx_ready, tc_flag, rx_valid, rc_flag, tx_pin, rx_pin, xck_in, xck_out;
   int bad_count = 0, n_compared = 0, cycles = 0;
   usart_clock_and_frame_format uut (.i_clock(i_clock), .i_rst(i_rst),
      .i_clock_en(1'b1), .i_cfg(cfg), .i_baud_divisor_high_byte(4'h0),
      .i_baud_divisor_low_byte(div_lo), .i_low_byte_write(low_wr),
      .i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_ninth_transmit_bit(ninth),
      .o_tx_ready(tx_ready), .o_transmit_complete_flag(tc_flag),
      .i_transmit_complete_clear(tc_clr), .o_rx_valid(rx_valid),
      .o_rx_word(rx_word), .o_receive_complete_flag(rc_flag),
      .i_receive_complete_clear(rc_clr), .i_serial_receive_pin(rx_pin),
      .o_serial_transmit_pin(tx_pin), .i_transfer_clock_pin(xck_in),
      .o_transfer_clock_pin(xck_out), .o_transfer_clock_oe(xck_oe));
   serial_peer peer (.i_clock(i_clock), .i_line_in(tx_pin), .i_hold_low(hold),
      .i_clk_run(cfg.sync_mode_select && !cfg.clock_pin_direction),
      .i_idle_level(cfg.sync_clock_polarity), .o_line_out(rx_pin),
      .o_ext_clock(xck_in));
   always #20 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 30000) begin
         bad_count++;
         final_report();
      end
   end
   task automatic check(input string what, input logic [12:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic set_div(input logic [7:0] v);
      @(negedge i_clock);
      div_lo = v;
      low_wr = 1'b1;
      @(negedge i_clock);
      low_wr = 1'b0;
   endtask
   // Sends a character and checks line and echo.
   task automatic xfer(input logic [8:0] d, input int nd, par, stops, per,
         brk, input logic fe);
      logic [12:0] got, exp;
      logic [8:0] m;
      int n, i;
      m = d & ~(9'h1FF << nd);
      got = '1;
      exp = '1;
      exp[0] = 1'b0;
      for (i = 0; i < nd; i++) exp[i + 1] = m[i];
      if (par != 0) exp[nd + 1] = ^m ^ par[0];
      n = 1 + nd + (par != 0) + stops;
      @(negedge i_clock);
      {ninth, tx_data} = d;
      tx_valid = 1'b1;
      @(negedge i_clock);
      tx_valid = 1'b0;
      for (i = 0; i < 400 && tx_pin !== 1'b0; i++) @(negedge i_clock);
      repeat (per / 2) @(negedge i_clock);
      for (i = 0; i < n; i++) begin
         got[i] = tx_pin;
         repeat (per / 2) @(negedge i_clock);
         hold = (i + 1 == brk);
         repeat (per - per / 2) @(negedge i_clock);
      end
      check("line bits", got, exp);
      check("rx data", 13'(rx_word.data), 13'(m));
      check("frame error", 13'(rx_word.frame_error_flag), 13'(fe));
      check("flags", 13'({rc_flag, tc_flag, rx_word.parity_error}),
         13'h006);
      rc_clr = 1'b1;
      tc_clr = 1'b1;
      @(negedge i_clock);
      rc_clr = 1'b0;
      tc_clr = 1'b0;
   endtask
   initial begin
      int sz, p, b, i, n;
      logic prev;
      repeat (8) @(negedge i_clock);
      i_rst = 1'b0;
      set_div(8'h01);
      for (sz = 0; sz < 5; sz++) begin
         for (p = 0; p < 3; p++) begin
            for (b = 0; b < 2; b++) begin
               cfg.char_size_field = (sz == 4) ? 3'h7 : 3'(sz);
               cfg.parity_mode_field = (p == 0) ? 2'h0 : 2'(p + 1);
               cfg.stop_bits_select = b[0];
               xfer(9'h15A + 9'(sz * 7 + p * 3 + b), (sz == 4) ? 9 : sz + 5,
                  (p == 0) ? 0 : p + 1, b + 1, 32, 99, 1'b0);
            end
         end
      end
      cfg.char_size_field = 3'h3;
      cfg.parity_mode_field = 2'h0;
      cfg.stop_bits_select = 1'b0;
      cfg.double_speed_select = 1'b1;
      set_div(8'h02);
      xfer(9'h0C3, 8, 0, 1, 24, 99, 1'b0);
      cfg.double_speed_select = 1'b0;
      set_div(8'h01);
      xfer(9'h055, 8, 0, 1, 32, 9, 1'b1);
      cfg.stop_bits_select = 1'b1;
      xfer(9'h0AA, 8, 0, 2, 32, 10, 1'b0);
      repeat (600) @(negedge i_clock);
      rc_clr = 1'b1;
      @(negedge i_clock);
      rc_clr = 1'b0;
      cfg.sync_mode_select = 1'b1;
      cfg.clock_pin_direction = 1'b1;
      repeat (4) @(negedge i_clock);
      check("master enable", 13'(xck_oe), 13'h001);
      n = 0;
      for (i = 0; i < 40; i++) begin
         prev = xck_out;
         @(negedge i_clock);
         if (!prev && xck_out) n++;
      end
      check("master clock rises", 13'(n), 13'h00A);
      cfg.clock_pin_direction = 1'b0;
      for (i = 0; i < 2; i++) begin
         cfg.sync_clock_polarity = i[0];
         repeat (3) @(negedge i_clock);
         check("slave pin", 13'({xck_oe, xck_out}), 13'(i));
         xfer(9'h0A5, 8, 0, 2, 8, 99, 1'b0);
      end
      final_report();
   end
endmodule
`default_nettype wire
